// *** hw/pcsm_consts.svh ***
// register indices, reset values, field codes and timing counts of the pll config slice
`ifndef PCSM_CONSTS_SVH
`define PCSM_CONSTS_SVH

// ============================================================
// register indices (byte address = index * 4)
`define PCSM_IDX_CTRL 10'h018
`define PCSM_IDX_ALIGN 10'h019
`define PCSM_IDX_STMON 10'h01a
`define PCSM_IDX_XFER 10'h020
`define PCSM_IDX_ISTAT 10'h021
`define PCSM_IDX_IMASK 10'h022
`define PCSM_IDX_MONST 10'h023

// ============================================================
// reset values
`define PCSM_CTRL_RST 8'h06
`define PCSM_ALIGN_RST 8'h00
`define PCSM_STMON_RST 8'h00
`define PCSM_IRQ_RST 4'h0

// ============================================================
// field codes and positions
`define PCSM_ALIGN_ASYNC 2'h1
`define PCSM_ALIGN_SYNC 2'h2
`define PCSM_CAL_DIV_BASE 5'h02
`define PCSM_XFER_BIT 0
`define PCSM_SDIV_MSB 1
`define PCSM_IRQ_W 4
`define PCSM_IRQ_CAL_DONE 0
`define PCSM_IRQ_REFA_LOST 1
`define PCSM_IRQ_REFB_LOST 2
`define PCSM_IRQ_ALIGN_HIT 3

// ============================================================
// timing
`define PCSM_CLK_NS 25
`define PCSM_WIN_NS 100000
`define PCSM_WIN_CYC (`PCSM_WIN_NS / `PCSM_CLK_NS)
`define PCSM_REF_HI_KHZ 1020
`define PCSM_VCO_KHZ 2000
`define PCSM_KHZ_TO_EDGES(k) (((k) * `PCSM_WIN_NS) / 1000000)
`define PCSM_CAL_TICKS 8'h40

`endif

// *** hw/pcsm_pkg.sv ***
// register layouts and state types of the pll config slice
package pcsm_pkg;

  typedef struct packed {
    logic [4:0] lock_cfg;
    logic [1:0] cal_div;
    logic cal_start;
  } pcsm_ctrl_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] ref_dly;
    logic [2:0] fb_dly;
  } pcsm_align_t;

  typedef struct packed {
    logic stat_div;
    logic ref_thr_low;
    logic [5:0] spare;
  } pcsm_stmon_t;

  typedef struct packed {
    logic ref_a;
    logic ref_b;
    logic vco;
  } pcsm_mon_t;

  typedef enum logic {
    PCSM_CAL_IDLE,
    PCSM_CAL_RUN
  } pcsm_cal_state_t;

endpackage

// *** hw/pcsm_cal_divider.sv ***
// divides reference edges down to the calibration clock tick
`timescale 1ns/1ps
`include "pcsm_consts.svh"

module pcsm_cal_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tick_in,
  input wire logic [1:0] code,
  output logic tick_q
);
  logic [4:0] cnt_q;
  logic [4:0] limit;
  logic [4:0] seen_q;
  logic [1:0] code_q;
  logic clean_q;

  assign limit = `PCSM_CAL_DIV_BASE << code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= limit - 5'h01) begin
          cnt_q <= 5'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // helper: reference ticks seen since the last output tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 5'h00;
    end else if (ce) begin
      if (tick_q) begin
        seen_q <= {4'h0, tick_in};
      end else if (tick_in) begin
        seen_q <= seen_q + 5'h01;
      end
    end
  end

  // helper: a period is only judged when the code held since the tick that opened it,
  // because a code change leaves the running count from the old ratio behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 2'h0;
      clean_q <= 1'b0;
    end else if (ce) begin
      code_q <= code;
      if (code != code_q) begin
        clean_q <= 1'b0;
      end else if (tick_q) begin
        clean_q <= 1'b1;
      end
    end
  end

  a_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tick_q) && $stable(code) && clean_q |-> seen_q == limit)
    else $error("calibration divider ratio wrong");

endmodule // pcsm_cal_divider

// *** hw/pcsm_freq_monitor.sv ***
// counts input edges over a fixed window and flags the frequency valid above a threshold
`timescale 1ns/1ps
`include "pcsm_consts.svh"

module pcsm_freq_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sig_in,
  input wire logic [11:0] thresh,
  output logic valid_q
);
  logic sig_prev_q;
  logic [11:0] win_q;
  logic [11:0] edges_q;
  logic [11:0] edges_d;
  logic win_end;

  assign edges_d = edges_q + {11'h000, sig_in & ~sig_prev_q};
  assign win_end = (win_q == 12'(`PCSM_WIN_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_prev_q <= 1'b0;
      win_q <= 12'h000;
      edges_q <= 12'h000;
      valid_q <= 1'b0;
    end else if (ce) begin
      sig_prev_q <= sig_in;
      if (win_end) begin
        win_q <= 12'h000;
        edges_q <= 12'h000;
        valid_q <= (edges_d > thresh);
      end else begin
        win_q <= win_q + 12'h001;
        edges_q <= edges_d;
      end
    end
  end

  a_mon_verdict: assert property (@(posedge pclk) disable iff (!presetn)
    ce && win_end |=> valid_q == ($past(edges_d) > $past(thresh)))
    else $error("monitor verdict does not match edge count");

endmodule // pcsm_freq_monitor

// *** hw/pcsm_top.sv ***
// pll configuration slice: calibration divider and start, alignment reset, path delays, status divider, monitors
//
// Contract
// - the calibration divider code selects divide by 2, 4, 8 or 16 and resets to divide by 16.
// - the alignment mode does nothing for 00 and 11, resets counters at once for 01, on a reference edge for 10.
// - reference and feedback path delay codes are separate fields that reset to zero.
// - with the status divider bit set the status pin shows its source divided by 4, else undivided.
// - with the threshold bit at 0 a reference counts as valid only above 1.02 MHz.
// - the threshold bit moves only the two reference monitors, never the oscillator monitor.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pcsm_consts.svh"

module pcsm_top #(
  parameter int REF_LOW_KHZ = 500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic fb_in,
  input wire logic vco_in,
  input wire logic align_n_in,
  input wire logic status_src,
  output logic status_pin,
  output logic cal_busy,
  output logic [2:0] ref_delay,
  output logic [2:0] fb_delay,
  output logic [7:0] ref_cnt,
  output logic [7:0] fb_cnt,
  output pcsm_pkg::pcsm_mon_t mon_valid,
  output logic irq
);
  // ============================================================
  // apb slave
  logic [9:0] idx;
  logic acc;
  logic wr;
  logic mapped;
  logic [7:0] rd_mux;

  assign idx = paddr[11:2];
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && ce;

  pcsm_pkg::pcsm_ctrl_t ctrl_sh_q;
  pcsm_pkg::pcsm_align_t align_sh_q;
  pcsm_pkg::pcsm_stmon_t stmon_sh_q;
  pcsm_pkg::pcsm_ctrl_t ctrl_act_q;
  pcsm_pkg::pcsm_align_t align_act_q;
  pcsm_pkg::pcsm_stmon_t stmon_act_q;
  logic [`PCSM_IRQ_W-1:0] ist_q;
  logic [`PCSM_IRQ_W-1:0] imask_q;
  logic [`PCSM_IRQ_W-1:0] events;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    unique case (idx)
      `PCSM_IDX_CTRL: rd_mux = ctrl_sh_q;
      `PCSM_IDX_ALIGN: rd_mux = align_sh_q;
      `PCSM_IDX_STMON: rd_mux = stmon_sh_q;
      `PCSM_IDX_XFER: rd_mux = 8'h00;
      `PCSM_IDX_ISTAT: rd_mux = {4'h0, ist_q};
      `PCSM_IDX_IMASK: rd_mux = {4'h0, imask_q};
      `PCSM_IDX_MONST: rd_mux = {4'h0, cal_busy, mon_valid};
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free access phase: answer is set up during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ============================================================
  // shadow and active registers
  logic xfer;

  assign xfer = wr && (idx == `PCSM_IDX_XFER) && pwdata[`PCSM_XFER_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh_q <= `PCSM_CTRL_RST;
      align_sh_q <= `PCSM_ALIGN_RST;
      stmon_sh_q <= `PCSM_STMON_RST;
    end else if (wr) begin
      if (idx == `PCSM_IDX_CTRL) begin
        ctrl_sh_q <= pwdata[7:0];
      end
      if (idx == `PCSM_IDX_ALIGN) begin
        align_sh_q <= pwdata[7:0];
      end
      if (idx == `PCSM_IDX_STMON) begin
        stmon_sh_q <= pwdata[7:0];
      end
    end
  end

  // ctrl, align and stmon settings act only after the transfer strobe, so a calibration can be
  // staged behind every other write that affects it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_act_q <= `PCSM_CTRL_RST;
      align_act_q <= `PCSM_ALIGN_RST;
      stmon_act_q <= `PCSM_STMON_RST;
    end else if (ce && xfer) begin
      ctrl_act_q <= ctrl_sh_q;
      align_act_q <= align_sh_q;
      stmon_act_q <= stmon_sh_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_delay <= 3'h0;
      fb_delay <= 3'h0;
    end else if (ce) begin
      ref_delay <= align_act_q.ref_dly;
      fb_delay <= align_act_q.fb_dly;
    end
  end

  a_delay_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ##1 ref_delay == 3'h0 && fb_delay == 3'h0)
    else $error("path delay codes not zero after reset");

  // ============================================================
  // reference edges, calibration clock and calibration run
  logic ref_prev_q;
  logic fb_prev_q;
  logic ref_edge;
  logic fb_edge;
  logic cal_tick;
  logic start_prev_q;
  logic launch;
  logic cal_done;
  logic [7:0] cal_cnt_q;
  pcsm_pkg::pcsm_cal_state_t cal_st_q;

  assign ref_edge = ref_a_in && !ref_prev_q;
  assign fb_edge = fb_in && !fb_prev_q;
  assign launch = ctrl_act_q.cal_start && !start_prev_q;
  assign cal_done = (cal_st_q == pcsm_pkg::PCSM_CAL_RUN) && cal_tick && (cal_cnt_q == `PCSM_CAL_TICKS - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
      fb_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else if (ce) begin
      ref_prev_q <= ref_a_in;
      fb_prev_q <= fb_in;
      start_prev_q <= ctrl_act_q.cal_start;
    end
  end

  pcsm_cal_divider u_cal_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick_in(ref_edge),
    .code(ctrl_act_q.cal_div),
    .tick_q(cal_tick)
  );

  // a new launch during a run is ignored; the oscillator divider must not be
  // in bypass meanwhile, which this slice cannot see
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st_q <= pcsm_pkg::PCSM_CAL_IDLE;
      cal_cnt_q <= 8'h00;
      cal_busy <= 1'b0;
    end else if (ce) begin
      unique case (cal_st_q)
        pcsm_pkg::PCSM_CAL_IDLE: begin
          if (launch) begin
            cal_st_q <= pcsm_pkg::PCSM_CAL_RUN;
            cal_cnt_q <= 8'h00;
            cal_busy <= 1'b1;
          end
        end
        pcsm_pkg::PCSM_CAL_RUN: begin
          if (cal_done) begin
            cal_st_q <= pcsm_pkg::PCSM_CAL_IDLE;
            cal_busy <= 1'b0;
          end else if (cal_tick) begin
            cal_cnt_q <= cal_cnt_q + 8'h01;
          end
        end
      endcase
    end
  end

  a_cal_launch: assert property (@(posedge pclk) disable iff (!presetn)
    ce && launch && !cal_busy |=> cal_busy)
    else $error("start bit rise did not launch calibration");

  a_cal_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cal_busy && start_prev_q && ctrl_act_q.cal_start |=> !cal_busy)
    else $error("held start bit launched a calibration");

  // ============================================================
  // counter alignment from the active-low alignment pin
  logic align_act;
  logic align_clr;

  assign align_act = !align_n_in;
  always_comb begin
    align_clr = 1'b0;
    unique case (align_act_q.mode)
      `PCSM_ALIGN_ASYNC: align_clr = align_act;
      `PCSM_ALIGN_SYNC: align_clr = align_act && ref_edge;
      default: align_clr = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 8'h00;
      fb_cnt <= 8'h00;
    end else if (ce) begin
      if (align_clr) begin
        ref_cnt <= 8'h00;
        fb_cnt <= 8'h00;
      end else begin
        ref_cnt <= ref_cnt + {7'h00, ref_edge};
        fb_cnt <= fb_cnt + {7'h00, fb_edge};
      end
    end
  end

  a_align_async: assert property (@(posedge pclk) disable iff (!presetn)
    ce && align_act_q.mode == `PCSM_ALIGN_ASYNC && align_act |=> ref_cnt == 8'h00 && fb_cnt == 8'h00)
    else $error("asynchronous alignment did not clear counters");

  a_align_idle: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (align_act_q.mode == 2'h0 || align_act_q.mode == 2'h3) && !ref_edge |=> $stable(ref_cnt))
    else $error("idle alignment mode disturbed counter");

  // ============================================================
  // status pin divider
  logic src_prev_q;
  logic [1:0] sdiv_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
      sdiv_q <= 2'h0;
      status_pin <= 1'b0;
    end else if (ce) begin
      src_prev_q <= status_src;
      if (status_src && !src_prev_q) begin
        sdiv_q <= sdiv_q + 2'h1;
      end
      status_pin <= stmon_act_q.stat_div ? sdiv_q[`PCSM_SDIV_MSB] : status_src;
    end
  end

  a_status_plain: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !stmon_act_q.stat_div |=> status_pin == $past(status_src))
    else $error("undivided status pin does not follow source");

  // ============================================================
  // frequency monitors; the threshold bit steers only the two references
  logic [11:0] ref_thr;
  logic [2:0] mon_raw;
  logic [2:0] mon_sig;
  logic [11:0] mon_thr [3];

  assign ref_thr = stmon_act_q.ref_thr_low ? 12'(`PCSM_KHZ_TO_EDGES(REF_LOW_KHZ))
                                           : 12'(`PCSM_KHZ_TO_EDGES(`PCSM_REF_HI_KHZ));
  assign mon_sig = {ref_a_in, ref_b_in, vco_in};
  assign mon_thr[2] = ref_thr;
  assign mon_thr[1] = ref_thr;
  assign mon_thr[0] = 12'(`PCSM_KHZ_TO_EDGES(`PCSM_VCO_KHZ));
  assign mon_valid = mon_raw;

  for (genvar i = 0; i < 3; i++) begin : g_mon
    pcsm_freq_monitor u_mon (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sig_in(mon_sig[i]),
      .thresh(mon_thr[i]),
      .valid_q(mon_raw[i])
    );
  end

  a_vco_thresh: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(stmon_act_q.ref_thr_low) |-> $stable(mon_thr[0]) && mon_thr[0] == 12'h0c8)
    else $error("oscillator threshold moved with reference bit");

  a_ref_thresh_hi: assert property (@(posedge pclk) disable iff (!presetn)
    !stmon_act_q.ref_thr_low |-> mon_thr[2] == 12'h066 && mon_thr[1] == 12'h066)
    else $error("reference threshold not at default level");

  // ============================================================
  // interrupts: sticky status, write one to clear, set beats clear
  logic [`PCSM_IRQ_W-1:0] ist_clr;
  logic refa_prev_q;
  logic refb_prev_q;

  always_comb begin
    events = `PCSM_IRQ_RST;
    events[`PCSM_IRQ_CAL_DONE] = cal_done;
    events[`PCSM_IRQ_REFA_LOST] = ce && !mon_valid.ref_a && refa_prev_q;
    events[`PCSM_IRQ_REFB_LOST] = ce && !mon_valid.ref_b && refb_prev_q;
    events[`PCSM_IRQ_ALIGN_HIT] = align_clr;
  end

  assign ist_clr = (wr && idx == `PCSM_IDX_ISTAT) ? pwdata[`PCSM_IRQ_W-1:0] : `PCSM_IRQ_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= `PCSM_IRQ_RST;
      imask_q <= `PCSM_IRQ_RST;
      irq <= 1'b0;
      refa_prev_q <= 1'b0;
      refb_prev_q <= 1'b0;
    end else if (ce) begin
      ist_q <= (ist_q & ~ist_clr) | events;
      if (wr && idx == `PCSM_IDX_IMASK) begin
        imask_q <= pwdata[`PCSM_IRQ_W-1:0];
      end
      irq <= |(((ist_q & ~ist_clr) | events) & imask_q);
      refa_prev_q <= mon_valid.ref_a;
      refb_prev_q <= mon_valid.ref_b;
    end
  end

endmodule // pcsm_top

// *** testbench/pcsm_host_model.sv ***
// apb host model that programs the pll config slice
`timescale 1ns/1ps
`include "pcsm_consts.svh"

module pcsm_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  logic [31:0] last_rd;
  logic last_err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    last_rd = 32'h0;
    last_err = 1'b0;
  end

  // ============================================================
  // one transfer; the request stands until pready is seen high at an edge
  task xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ============================================================
  // start bit is seen 0 then 1 in the active copy; the oscillator output
  // divider lives elsewhere and is never put in bypass here
  task cal_launch(input logic [1:0] code);
    xfer(1'b1, `PCSM_IDX_CTRL, {24'h0, 5'h00, code, 1'b0});
    xfer(1'b1, `PCSM_IDX_XFER, 32'h1);
    xfer(1'b1, `PCSM_IDX_CTRL, {24'h0, 5'h00, code, 1'b1});
    xfer(1'b1, `PCSM_IDX_XFER, 32'h1);
  endtask
endmodule // pcsm_host_model

// *** testbench/test_pll_cal_sync_monitor_ctrl.sv ***
// self-checking bench of the pll config slice
`timescale 1ns/1ps
`include "pcsm_consts.svh"

module test_pll_cal_sync_monitor_ctrl;
  typedef struct {
    logic [9:0] idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic err;
  } pcsm_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ref_a_in = 1'b0, ref_b_in = 1'b0, fb_in = 1'b0, vco_in = 1'b0;
  logic align_n_in = 1'b1, status_src = 1'b0;
  logic status_pin, cal_busy, irq, ref_a_q, stat_q;
  logic [2:0] ref_delay, fb_delay;
  logic [7:0] ref_cnt, fb_cnt, v1, v2;
  pcsm_pkg::pcsm_mon_t mon_valid;
  int fails = 0, n_checks = 0, cyc = 0, cal_edges = 0, stat_rises = 0, n;
  pcsm_row_t rows [8];

  always #12.5 pclk = ~pclk;

  pcsm_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  pcsm_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ref_a_in(ref_a_in), .ref_b_in(ref_b_in), .fb_in(fb_in), .vco_in(vco_in), .align_n_in(align_n_in),
    .status_src(status_src), .status_pin(status_pin), .cal_busy(cal_busy), .ref_delay(ref_delay),
    .fb_delay(fb_delay), .ref_cnt(ref_cnt), .fb_cnt(fb_cnt), .mon_valid(mon_valid), .irq(irq));

  // ============================================================
  // stimulus clocks: ref_a 10 MHz keeps every divider code usable
  // ref_b 0.8 MHz sits between the two thresholds, vco 1.54 MHz below its own
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ref_a_in <= ((cyc / 2) % 2) == 1;
    fb_in <= ((cyc / 3) % 2) == 1;
    ref_b_in <= ((cyc / 25) % 2) == 1;
    vco_in <= ((cyc / 13) % 2) == 1;
    ref_a_q <= ref_a_in;
    stat_q <= status_pin;
    if (cal_busy === 1'b1 && ref_a_in && !ref_a_q) cal_edges <= cal_edges + 1;
    if (status_pin === 1'b1 && stat_q === 1'b0) stat_rises <= stat_rises + 1;
    if (cyc > 60000) begin
      fails++;
      stop_test();
    end
  end

  // ============================================================
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d);
  endtask

  task rdchk(input logic [9:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 32'h0);
    check(host.last_rd, exp);
  endtask

  task stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ============================================================
  initial begin
    rows[0] = '{`PCSM_IDX_CTRL, 32'ha5, 32'ha5, 1'b0};
    rows[1] = '{`PCSM_IDX_ALIGN, 32'h2a, 32'h2a, 1'b0};
    rows[2] = '{`PCSM_IDX_STMON, 32'hc0, 32'hc0, 1'b0};
    rows[3] = '{`PCSM_IDX_XFER, 32'h0, 32'h0, 1'b0};
    rows[4] = '{`PCSM_IDX_IMASK, 32'h0e, 32'h0e, 1'b0};
    rows[5] = '{10'h030, 32'hff, 32'h0, 1'b1};
    rows[6] = '{`PCSM_IDX_IMASK, 32'h0, 32'h0, 1'b0};
    rows[7] = '{`PCSM_IDX_ISTAT, 32'h0f, 32'h0, 1'b0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    rdchk(`PCSM_IDX_CTRL, 32'h06);
    rdchk(`PCSM_IDX_ALIGN, 32'h00);
    rdchk(`PCSM_IDX_STMON, 32'h00);
    check(irq, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].rd);
      check(host.last_err, rows[i].err);
    end
    // calibration length per divider code; busy must rise only on the launch
    for (int c = 0; c < 4; c++) begin
      tick(0);
      cal_edges = 0;
      host.cal_launch(c[1:0]);
      tick(1);
      check(cal_busy, 1'b1);
      n = 0;
      while (cal_busy === 1'b1 && n < 6000) begin
        @(negedge pclk);
        n++;
      end
      n = 64 * (2 << c);
      // the divider runs freely, so the first tick of a run may be short by up to one period
      check({31'h0, cal_edges >= n - (2 << c) - 2 && cal_edges <= n + 2}, 32'h1);
    end
    wr(`PCSM_IDX_XFER, 32'h1);
    tick(3);
    check(cal_busy, 1'b0);
    check(irq, 1'b0);
    rdchk(`PCSM_IDX_ISTAT, 32'h1);
    wr(`PCSM_IDX_IMASK, 32'h1);
    tick(2);
    check(irq, 1'b1);
    wr(`PCSM_IDX_ISTAT, 32'h1);
    tick(2);
    check(irq, 1'b0);
    // alignment modes with delays held at ref 5, fb 2
    for (int m = 0; m < 4; m++) begin
      wr(`PCSM_IDX_ALIGN, 32'(m * 64 + 8'h2a));
      wr(`PCSM_IDX_XFER, 32'h1);
      tick(2);
      check(ref_delay, 3'h5);
      check(fb_delay, 3'h2);
      @(posedge pclk) align_n_in <= 1'b0;
      tick(40);
      v1 = ref_cnt;
      v2 = fb_cnt;
      tick(8);
      check({31'h0, ref_cnt === 8'h00 && v1 === 8'h00}, 32'(m == 1 || m == 2));
      if (m != 2) check({31'h0, fb_cnt === 8'h00 && v2 === 8'h00}, 32'(m == 1));
      @(posedge pclk) align_n_in <= 1'b1;
    end
    // status pin plain then divided: rises seen over eight source pulses
    for (int sd = 0; sd < 2; sd++) begin
      wr(`PCSM_IDX_STMON, 32'(sd * 128));
      wr(`PCSM_IDX_XFER, 32'h1);
      tick(2);
      stat_rises = 0;
      repeat (8) begin
        @(posedge pclk) status_src <= 1'b1;
        repeat (2) @(posedge pclk);
        status_src <= 1'b0;
        repeat (2) @(posedge pclk);
      end
      tick(4);
      check(stat_rises, sd ? 32'h2 : 32'h8);
    end
    // threshold high, then lowered, then back so ref_b loses validity
    for (int k = 0; k < 3; k++) begin
      wr(`PCSM_IDX_STMON, (k == 1) ? 32'h40 : 32'h0);
      wr(`PCSM_IDX_XFER, 32'h1);
      tick(9000);
      check(mon_valid, (k == 1) ? 3'b110 : 3'b100);
    end
    rdchk(`PCSM_IDX_ISTAT, 32'h0c);
    rdchk(`PCSM_IDX_MONST, 32'h04);
    // clock enable low freezes the counters
    @(posedge pclk) ce <= 1'b0;
    tick(1);
    v1 = ref_cnt;
    tick(6);
    check(ref_cnt, v1);
    @(posedge pclk) ce <= 1'b1;
    // second reset in mid-run
    @(posedge pclk) presetn <= 1'b0;
    tick(4);
    @(posedge pclk) presetn <= 1'b1;
    tick(2);
    rdchk(`PCSM_IDX_CTRL, 32'h06);
    rdchk(`PCSM_IDX_ALIGN, 32'h00);
    check(ref_delay, 3'h0);
    check(status_pin, 1'b0);
    stop_test();
  end
endmodule // test_pll_cal_sync_monitor_ctrl
